/* File: dibit_constellation_mapper.sv */
// Dibit FIFO and the constellation mapper with its APB register slave
// Assumes bit_clk and bit_data are synchronous to mclk, bit_clk < mclk/2
`timescale 1ns/10ps
`include "dcm_regs.svh"

module dcm_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16,
    parameter int LW = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [LW-1:0] level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [LW-1:0] cnt_ff, nxt_cnt;
    logic do_wr, do_rd;

    assign in_ready = cnt_ff < LW'(DEPTH);
    assign out_valid = cnt_ff != '0;
    assign out_data = mem_ff[rd_ff];
    assign level = cnt_ff;
    assign do_wr = in_valid & in_ready;
    assign do_rd = out_ready & out_valid;

    always_comb begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (do_wr) begin
            nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
        end
        if (do_rd) begin
            nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
        end
        if (do_wr && !do_rd) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (do_rd && !do_wr) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule

module dibit_constellation_mapper import dcm_pkg::*; #(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial source
    input wire logic bit_clk,
    input wire logic bit_data,
    output logic src_ready,
    // Symbol outputs
    output logic symbol_rate_pulse,
    output iq_t iq
);
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    function automatic scheme_t pick_scheme(input logic [3:0] ctrl);
        if (ctrl[`CTRL_FAMILY]) begin
            return SCH_PI4;
        end
        case (ctrl[`CTRL_SCHEME_HI:`CTRL_SCHEME_LO])
            2'h1: return SCH_OFFSET;
            2'h2: return SCH_MINSHIFT;
            default: return SCH_DIFF;
        endcase
    endfunction

    function automatic logic signed [3:0] lvl(input logic neg,
                                              input logic [3:0] amp);
        return neg ? -$signed(amp) : $signed(amp);
    endfunction

    // Eight-phase circle, index k is k*45 deg
    function automatic iq_t phase_iq(input logic [2:0] k);
        iq_t r;
        r.i = '0;
        r.q = '0;
        case (k)
            3'h0: r.i = lvl(1'b0, `AMP_FULL);
            3'h2: r.q = lvl(1'b0, `AMP_FULL);
            3'h4: r.i = lvl(1'b1, `AMP_FULL);
            3'h6: r.q = lvl(1'b1, `AMP_FULL);
            default: begin
                r.i = lvl(k == 3'h3 || k == 3'h5, `AMP_DIAG);
                r.q = lvl(k[2], `AMP_DIAG);
            end
        endcase
        return r;
    endfunction

    // Dibit capture
    logic bclk_q_ff, nxt_bclk_q;
    logic first_bit_ff, nxt_first_bit;
    bit_phase_t half_ff, nxt_half;
    logic bit_rise, tick, mid;
    logic fifo_in_ready, fifo_valid, pop;
    logic [1:0] fifo_dout;
    logic [LW-1:0] fifo_level;

    assign bit_rise = bit_clk & ~bclk_q_ff;
    assign tick = bit_rise && half_ff == PH_SECOND;
    assign mid = bit_rise && half_ff == PH_FIRST;

    always_comb begin
        nxt_bclk_q = bit_clk;
        nxt_first_bit = first_bit_ff;
        nxt_half = half_ff;
        if (mid) begin
            nxt_first_bit = bit_data;
            nxt_half = PH_SECOND;
        end else if (tick) begin
            nxt_half = PH_FIRST;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bclk_q_ff <= 1'b0;
            first_bit_ff <= 1'b0;
            half_ff <= PH_FIRST;
        end else begin
            bclk_q_ff <= nxt_bclk_q;
            first_bit_ff <= nxt_first_bit;
            half_ff <= nxt_half;
        end
    end

    dcm_fifo #(.WIDTH(2), .DEPTH(FIFO_DEPTH), .LW(LW)) u_fifo (
        .clk(mclk),
        .rst(sys_rst),
        .in_valid(tick),
        .in_ready(fifo_in_ready),
        .in_data({first_bit_ff, bit_data}),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_dout),
        .level(fifo_level)
    );

    // Registers and symbol engine state
    logic [3:0] ctrl_ff, nxt_ctrl;
    logic overrun_ff, nxt_overrun;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic src_ready_ff;
    logic symbol_rate_pulse_ff, nxt_symbol_rate_pulse;
    logic [2:0] phase_ff, nxt_phase;
    logic alt_ff, nxt_alt;
    logic have_ff, nxt_have;
    logic [1:0] cur_ff, nxt_cur;
    iq_t iq_ff, nxt_iq;
    scheme_t act;
    logic wr_acc;

    assign act = pick_scheme(ctrl_ff);
    assign pop = tick & ctrl_ff[`CTRL_RUN] & fifo_valid;
    assign wr_acc = psel & penable & pready_ff & pwrite;

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_overrun = overrun_ff;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        if (wr_acc && paddr == `OFF_CTRL) begin
            nxt_ctrl = pwdata[3:0];
        end
        if (wr_acc && paddr == `OFF_STATUS && pwdata[`STAT_OVERRUN]) begin
            nxt_overrun = 1'b0;
        end
        if (tick && !fifo_in_ready) begin
            nxt_overrun = 1'b1;
        end
        if (psel && !penable) begin
            nxt_pready = 1'b1;
            nxt_prdata = '0;
            case (paddr)
                `OFF_CTRL: nxt_prdata[3:0] = ctrl_ff;
                `OFF_STATUS: begin
                    nxt_prdata[LW-1:0] = fifo_level;
                    nxt_prdata[`STAT_OVERRUN] = overrun_ff;
                    nxt_prdata[13:12] = act;
                    nxt_prdata[18:16] = phase_ff;
                    nxt_prdata[20] = alt_ff;
                end
                `OFF_SYMBOL: nxt_prdata[7:0] = iq_ff;
                default: nxt_pslverr = 1'b1;
            endcase
        end
    end

    always_comb begin
        nxt_symbol_rate_pulse = symbol_rate_pulse_ff;
        nxt_phase = phase_ff;
        nxt_alt = alt_ff;
        nxt_have = have_ff;
        nxt_cur = cur_ff;
        nxt_iq = iq_ff;
        if (tick) begin
            nxt_symbol_rate_pulse = 1'b1;
        end else if (mid) begin
            nxt_symbol_rate_pulse = 1'b0;
        end
        if (pop) begin
            nxt_have = 1'b1;
            nxt_cur = fifo_dout;
            case (act)
                SCH_DIFF: begin
                    case (fifo_dout)
                        2'b00: nxt_phase = phase_ff + `STEP_00;
                        2'b01: nxt_phase = phase_ff + `STEP_01;
                        2'b10: nxt_phase = phase_ff + `STEP_10;
                        default: nxt_phase = phase_ff + `STEP_11;
                    endcase
                    nxt_iq = phase_iq(nxt_phase);
                end
                SCH_PI4: begin
                    // Gray quadrants, odd phases plain, even phases primed
                    nxt_phase = {fifo_dout[1], ^fifo_dout, ~alt_ff};
                    nxt_alt = ~alt_ff;
                    nxt_iq = phase_iq(nxt_phase);
                end
                SCH_OFFSET: begin
                    nxt_iq.i = lvl(fifo_dout[1], `AMP_FULL);
                end
                default: begin
                    // Half-sine: i starts at zero, q at its peak
                    nxt_iq.i = '0;
                    nxt_iq.q = lvl(cur_ff[0], `AMP_FULL);
                end
            endcase
        end else if (mid && have_ff) begin
            if (act == SCH_OFFSET) begin
                nxt_iq.q = lvl(cur_ff[0], `AMP_FULL);
            end else if (act == SCH_MINSHIFT) begin
                nxt_iq.i = lvl(cur_ff[1], `AMP_FULL);
                nxt_iq.q = '0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_ff <= `CTRL_RESET;
            overrun_ff <= 1'b0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
            src_ready_ff <= 1'b0;
            symbol_rate_pulse_ff <= 1'b0;
            phase_ff <= '0;
            alt_ff <= 1'b0;
            have_ff <= 1'b0;
            cur_ff <= '0;
            iq_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            overrun_ff <= nxt_overrun;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
            src_ready_ff <= fifo_in_ready;
            symbol_rate_pulse_ff <= nxt_symbol_rate_pulse;
            phase_ff <= nxt_phase;
            alt_ff <= nxt_alt;
            have_ff <= nxt_have;
            cur_ff <= nxt_cur;
            iq_ff <= nxt_iq;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign src_ready = src_ready_ff;
    assign symbol_rate_pulse = symbol_rate_pulse_ff;
    assign iq = iq_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_symbol_rate_pulse_rise: assert property (tick |=> symbol_rate_pulse_ff)
        else $error("symbol clock not high");
    a_symbol_rate_pulse_hold: assert property (!tick && !mid |=>
        symbol_rate_pulse_ff == $past(symbol_rate_pulse_ff)) else $error("symbol clock moved");
    a_symbol_rate_pulse_fall: assert property (mid |=> !symbol_rate_pulse_ff)
        else $error("symbol clock not low");
    a_first_digit: assert property (mid |=>
        first_bit_ff == $past(bit_data)) else $error("first bit lost");
    a_diff_step: assert property (pop && act == SCH_DIFF &&
        fifo_dout == 2'b01 |=> phase_ff == $past(phase_ff) + 3'h3)
        else $error("dqpsk step wrong");
    a_diff_moves: assert property (pop && act == SCH_DIFF |=>
        phase_ff != $past(phase_ff)) else $error("dqpsk phase held");
    a_pi4_alt: assert property (pop && act == SCH_PI4 |=>
        phase_ff[0] == !$past(alt_ff) && alt_ff != $past(alt_ff))
        else $error("pi4 constellation not alternating");
    a_jumper_fixed: assert property (ctrl_ff[`CTRL_FAMILY] |->
        act == SCH_PI4) else $error("selector not ignored");
    a_offset_hold: assert property (mid && have_ff &&
        act == SCH_OFFSET |=> iq_ff.i == $past(iq_ff.i))
        else $error("offset i moved at mid symbol");
    a_msk_shape: assert property (pop && act == SCH_MINSHIFT |=>
        iq_ff.i == 4'h0 && iq_ff.q != 4'h0) else $error("msk shape wrong");
    a_update_tick: assert property ($changed(iq_ff) &&
        act != SCH_OFFSET && act != SCH_MINSHIFT |-> $past(tick))
        else $error("output moved off symbol edge");

    c_diff_run: cover property (pop && act == SCH_DIFF);
    c_pi4_run: cover property (pop && act == SCH_PI4 ##[1:100] pop);
    c_msk_mid: cover property (mid && have_ff && act == SCH_MINSHIFT);
    c_overrun: cover property (tick && !fifo_in_ready);
endmodule

/* File: dcm_regs.svh */
// Register offsets, field positions, reset values and level constants
// Assumes inclusion by the mapper file only
`ifndef DCM_REGS_SVH
`define DCM_REGS_SVH
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_SYMBOL 12'h008
`define CTRL_FAMILY 0
`define CTRL_SCHEME_LO 1
`define CTRL_SCHEME_HI 2
`define CTRL_RUN 3
`define CTRL_RESET 4'h0
`define STAT_OVERRUN 8
`define AMP_FULL 4'h4
`define AMP_DIAG 4'h3
`define STEP_00 3'h1
`define STEP_01 3'h3
`define STEP_10 3'h7
`define STEP_11 3'h5
`endif

/* File: dcm_pkg.sv */
// Types shared by the dibit constellation mapper
// Assumes the constants header carries the offsets, control bits, levels and phase steps
package dcm_pkg;
    typedef enum logic [1:0] {
        SCH_DIFF,
        SCH_OFFSET,
        SCH_MINSHIFT,
        SCH_PI4
    } scheme_t;
    typedef enum logic {
        PH_FIRST,
        PH_SECOND
    } bit_phase_t;
    typedef struct packed {
        logic signed [3:0] i;
        logic signed [3:0] q;
    } iq_t;
endpackage

/* File: serial_src.sv */
// Behavioural serial source: bit clock and data for the mapper
// Assumes one bench process calls send_dibit at a time
`timescale 1ns/10ps
module serial_src (
    // Clock
    input wire logic mclk,
    // Serial lines
    output logic bit_clk,
    output logic bit_data
);
    initial begin
        bit_clk = 1'b0;
        bit_data = 1'b0;
    end
    // Data moves only with the bit clock rising; clock idles low
    task automatic send_bit(input logic b, input int gap);
        @(posedge mclk);
        bit_clk <= 1'b1;
        bit_data <= b;
        repeat (2) @(posedge mclk);
        bit_clk <= 1'b0;
        repeat (2 + gap) @(posedge mclk);
    endtask
    task automatic send_dibit(input logic [1:0] d, input int gap);
        send_bit(d[1], 0);
        send_bit(d[0], gap);
    endtask
endmodule

/* File: dibit_constellation_mapper_tb.sv */
// Self-checking bench for the mapper, with a scheme model
// Assumes serial_src drives the serial lines
`timescale 1ns/10ps
module dibit_constellation_mapper_tb import dcm_pkg::*;;
    logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, bit_clk, bit_data, src_ready;
    logic symbol_rate_pulse, sp_q = 1'b0, alt;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [1:0] d, pd, sent[$];
    iq_t iq;
    int err_total = 0, tests_run = 0, k = 0, ph = 0, mode = -1;
    int st[4] = '{1, 3, 7, 5};
    always #25 mclk = ~mclk;
    dibit_constellation_mapper #(.FIFO_DEPTH(16)) DUT (.mclk(mclk),
        .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bit_clk(bit_clk), .bit_data(bit_data),
        .src_ready(src_ready), .symbol_rate_pulse(symbol_rate_pulse),
        .iq(iq));
    serial_src src (.mclk(mclk), .bit_clk(bit_clk), .bit_data(bit_data));
    function automatic logic [7:0] pt(input int p);
        int c[8] = '{4, 3, 0, -3, -4, -3, 0, 3};
        return {4'(c[p % 8]), 4'(c[(p + 6) % 8])};
    endfunction
    function automatic logic [3:0] lv(input logic b);
        return b ? 4'hC : 4'h4;
    endfunction
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_iq(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t iq got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic reset_dut;
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        k = 0;
        ph = 0;
        alt = 1'b0;
        sent.delete();
    endtask
    task automatic end_of_test;
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Model of the shown symbol at each symbol clock edge
    always @(negedge mclk) begin
        if (!sys_rst && symbol_rate_pulse && !sp_q) begin
            k++;
            if (k < 2 || mode < 0) cmp_iq(iq, 8'h00);
            else begin
                d = sent[k - 2];
                case (mode)
                    0: begin
                        ph = (ph + st[d]) % 8;
                        cmp_iq(iq, pt(ph));
                    end
                    3: begin
                        ph = {d[1], d[1] ^ d[0], ~alt};
                        alt = ~alt;
                        cmp_iq(iq, pt(ph));
                    end
                    1: cmp_iq(iq & 8'hF0, {lv(d[1]), 4'h0});
                    default: cmp_iq(iq & (k > 2 ? 8'hFF : 8'hF0),
                        {4'h0, lv(pd[0])} & (k > 2 ? 8'hFF : 8'hF0));
                endcase
                pd = d;
            end
        end
        if (!sys_rst && !symbol_rate_pulse && sp_q && k >= 2) begin
            if (mode == 1) cmp_iq(iq & 8'h0F, {4'h0, lv(pd[0])});
            if (mode == 2) cmp_iq(iq, {lv(pd[1]), 4'h0});
        end
        sp_q = symbol_rate_pulse;
    end
    task automatic run_mode(input logic fam, input logic [1:0] sch);
        logic [31:0] rd;
        logic e;
        logic [1:0] v;
        reset_dut();
        mode = fam ? 3 : (sch == 2'h3 ? 0 : int'(sch));
        apb(1'b1, 12'h000, {28'h0, 1'b1, sch, fam}, rd, e);
        apb(1'b0, 12'h004, 32'h0, rd, e);
        cmp_reg(rd[13:12], mode);
        for (int n = 0; n < 14; n++) begin
            v = (n < 3) ? 2'h3 : 2'($urandom);
            sent.push_back(v);
            src.send_dibit(v, $urandom % 3);
        end
        repeat (6) @(posedge mclk);
        $display("Scheme test fam=%0d sel=%0d done", fam, sch);
    endtask
    initial begin
        logic [31:0] rd;
        logic e;
        void'($urandom(32'h5dd8));
        reset_dut();
        cmp_iq(iq, 8'h00);
        for (int a = 0; a < 12; a += 4) begin
            apb(1'b0, 12'(a), 32'h0, rd, e);
            cmp_reg(rd, 32'h0);
        end
        cmp_reg(src_ready, 1'b1);
        apb(1'b1, 12'h00C, 32'hF, rd, e);
        cmp_reg(e, 1'b1);
        apb(1'b0, 12'h00C, 32'h0, rd, e);
        cmp_reg(e, 1'b1);
        cmp_reg(rd, 32'h0);
        apb(1'b0, 12'h000, 32'h0, rd, e);
        cmp_reg(rd, 32'h0);
        // Run off: seventeen dibits overfill the buffer
        for (int n = 0; n < 17; n++) src.send_dibit(2'($urandom), 0);
        cmp_reg(src_ready, 1'b0);
        apb(1'b0, 12'h004, 32'h0, rd, e);
        cmp_reg(rd[8:0], 9'h110);
        apb(1'b1, 12'h004, 32'h100, rd, e);
        apb(1'b0, 12'h004, 32'h0, rd, e);
        cmp_reg(rd[8], 1'b0);
        $display("Register and buffer test done");
        run_mode(1'b0, 2'h0);
        run_mode(1'b0, 2'h1);
        run_mode(1'b0, 2'h2);
        run_mode(1'b0, 2'h3);
        run_mode(1'b1, 2'h2);
        end_of_test();
    end
    initial begin
        #1000000;
        err_total++;
        end_of_test();
    end
endmodule
